// file: psh_params.svh
// Purpose: Register indices, field positions, reset values and bus constants of the
//          strobed handshake parallel port.
// Assumes: One port group (ports A, B and the handshake status word) on AHB-Lite.
// Notes:   Byte address of a register is four times its index.
// Behaviour
// - Input mode: status bit 0 is port B request, gated by its enable.
// - Input mode: status word never shows the incoming strobe line levels.
// - Port A output mode leaves lines 4 and 5 as general-purpose lines.
// - Port A bidirectional with port B strobed leaves no port C line for general use; port A strobed leaves two.
// - Status layout differs for input and output modes; output layout in output mode.
// - Output mode: bit 7 is active-low port A output-full, low after host write.
// - Output mode: bit 6 is port A enable, changed only by bit set/reset.
// - Port A output mode: bits 5 and 4 are general-purpose, driven by set/reset.
// - Output mode: bit 3 is port A request gated by its enable.
// - Output mode: bit 2 is port B enable, changed only by bit set/reset.
// - Output mode: bit 1 is active-low port B output-full, low after host write.
// - Output mode: bit 0 is port B request.
// - Output mode: status word never shows acknowledge line levels.
// - Bidirectional mode: port A moves data both ways under handshake lines.
// - Bidirectional mode is port A only; port B basic or strobed.
// - Port A bidirectional, port B basic: lines 2 to 0 stay general-purpose.
// - Configuration write with top bit clear sets or clears one port C bit.
// - Input mode: port A input-full goes high once data is latched.
`ifndef PSH_PARAMS_SVH
`define PSH_PARAMS_SVH

// Register indices; byte address is the index times four.
`define PSH_IDX_PORTA 4'h0
`define PSH_IDX_PORTB 4'h1
`define PSH_IDX_STATUS1 4'h2
`define PSH_IDX_CFG 4'h3
`define PSH_IDX_STATUS2 4'h6
`define PSH_IDX_STATUS3 4'hA
`define PSH_IDX_STATUS4 4'hE

// Port C line positions.
`define PSH_PC_PORT_B_IRQ_REQUEST 0
`define PSH_PC_FLAGB 1
`define PSH_PC_PORT_B_STROBE_N 2
`define PSH_PC_PORT_A_IRQ_REQUEST 3
`define PSH_PC_PORT_A_STROBE_N 4
`define PSH_PC_PORT_A_INPUT_FULL 5
`define PSH_PC_PORT_A_ACK_N 6
`define PSH_PC_PORT_A_OUTPUT_FULL_N 7

// Reset values.
`define PSH_CFG_RST 8'h9B
`define PSH_BYTE_RST 8'h00

`endif

// file: psh_pkg.sv
// Purpose: Types of the strobed handshake parallel port.
// Assumes: Field order of the configuration word is bit 7 down to bit 0.
// Notes:   None.
`default_nettype none
package psh_pkg;
   // Decoded operating mode of port A.
   typedef enum logic [1:0] {GA_BASIC, GA_STROBED, GA_BIDIR} psh_amode_t;

   // Configuration word as written by software.
   typedef struct packed {
      logic set_mode;
      logic [1:0] a_mode;
      logic a_in;
      logic cu_in;
      logic b_mode;
      logic b_in;
      logic cl_in;
   } psh_cfg_t;
endpackage
`default_nettype wire

// file: psh_ppi_top.sv
// Purpose: Three-port parallel interface with strobed and bidirectional handshakes.
// Assumes: Pins are synchronous to hclk; AHB-Lite single word transfers.
// Notes:   Handshake strobes and acknowledges arrive on port C input lines.
//
// The AHB-Lite slave port was chosen for this implementation.
`include "psh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module psh_ppi_top
   import psh_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] pa_i,
   output logic [7:0] pa_o,
   output logic pa_oe,
   input wire logic [7:0] pb_i,
   output logic [7:0] pb_o,
   output logic pb_oe,
   input wire logic [7:0] pc_i,
   output logic [7:0] pc_o,
   output logic [7:0] pc_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   psh_cfg_t cfg_q;
   logic [7:0] pc_out_q;
   logic [7:0] pa_lat_q;
   logic [7:0] pb_lat_q;
   logic [7:0] pa_in_q;
   logic [7:0] pb_in_q;
   logic [7:0] pc_prev_q;
   logic [7:0] pc_was_in_q;
   logic ibf_a_q;
   logic obf_a_n_q;
   logic intr_ai_q;
   logic intr_ao_q;
   logic ibf_b_q;
   logic obf_b_n_q;
   logic intr_b_q;
   logic wr_pend_q;
   logic [3:0] wr_idx_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode and handshake line events.
   psh_amode_t amode;
   logic a_hs_in;
   logic a_hs_out;
   logic b_hs;
   logic stb_a_fall;
   logic stb_a_rise;
   logic ack_a_fall;
   logic ack_a_rise;
   logic hs_b_fall;
   logic hs_b_rise;
   logic [7:0] pin_in;

   // Port A is bidirectional in mode 2, strobed in mode 1; port B strobed or basic.
   always_comb begin
      if (cfg_q.a_mode[1]) begin
         amode = GA_BIDIR;
      end else if (cfg_q.a_mode[0]) begin
         amode = GA_STROBED;
      end else begin
         amode = GA_BASIC;
      end
   end

   assign a_hs_in = (amode == GA_STROBED && cfg_q.a_in) || amode == GA_BIDIR;
   assign a_hs_out = (amode == GA_STROBED && !cfg_q.a_in) || amode == GA_BIDIR;
   assign b_hs = cfg_q.b_mode;
   // Edges count only on lines that were released at the last two samples.
   assign pin_in = pc_was_in_q & ~pc_oe;
   assign stb_a_fall = a_hs_in && pin_in[`PSH_PC_PORT_A_STROBE_N]
      && pc_prev_q[`PSH_PC_PORT_A_STROBE_N] && !pc_i[`PSH_PC_PORT_A_STROBE_N];
   assign stb_a_rise = a_hs_in && pin_in[`PSH_PC_PORT_A_STROBE_N]
      && !pc_prev_q[`PSH_PC_PORT_A_STROBE_N] && pc_i[`PSH_PC_PORT_A_STROBE_N];
   assign ack_a_fall = a_hs_out && pin_in[`PSH_PC_PORT_A_ACK_N]
      && pc_prev_q[`PSH_PC_PORT_A_ACK_N] && !pc_i[`PSH_PC_PORT_A_ACK_N];
   assign ack_a_rise = a_hs_out && pin_in[`PSH_PC_PORT_A_ACK_N]
      && !pc_prev_q[`PSH_PC_PORT_A_ACK_N] && pc_i[`PSH_PC_PORT_A_ACK_N];
   assign hs_b_fall = b_hs && pin_in[`PSH_PC_PORT_B_STROBE_N]
      && pc_prev_q[`PSH_PC_PORT_B_STROBE_N] && !pc_i[`PSH_PC_PORT_B_STROBE_N];
   assign hs_b_rise = b_hs && pin_in[`PSH_PC_PORT_B_STROBE_N]
      && !pc_prev_q[`PSH_PC_PORT_B_STROBE_N] && pc_i[`PSH_PC_PORT_B_STROBE_N];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic addr_ph;
   logic mapped;
   logic [3:0] idx;
   logic rd_a;
   logic rd_b;
   logic wr_a;
   logic wr_b;
   logic wr_c;
   logic wr_cfg;
   logic mode_wr;
   logic bsr_wr;

   assign addr_ph = hsel && htrans[1] && hready;
   assign mapped = haddr[31:6] == 26'h0000000;
   assign idx = haddr[5:2];
   assign rd_a = addr_ph && !hwrite && mapped && idx == `PSH_IDX_PORTA;
   assign rd_b = addr_ph && !hwrite && mapped && idx == `PSH_IDX_PORTB;
   assign wr_a = wr_pend_q && wr_idx_q == `PSH_IDX_PORTA;
   assign wr_b = wr_pend_q && wr_idx_q == `PSH_IDX_PORTB;
   assign wr_c = wr_pend_q && wr_idx_q == `PSH_IDX_STATUS1;
   assign wr_cfg = wr_pend_q && wr_idx_q == `PSH_IDX_CFG;
   assign mode_wr = wr_cfg && hwdata[7];
   assign bsr_wr = wr_cfg && !hwdata[7];

   // A write is remembered from its address phase and applied in its data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 4'h0;
      end else begin
         wr_pend_q <= addr_ph && hwrite && mapped;
         wr_idx_q <= idx;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration word; a mode write replaces it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= `PSH_CFG_RST;
      end else if (mode_wr) begin
         cfg_q <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port C ownership: which lines the handshakes take over.
   logic [7:0] hs_mask;
   logic [7:0] hs_drv;
   logic [7:0] hs_v;
   logic [7:0] gpio_oe;
   logic port_a_irq_request;
   logic port_b_irq_request;

   // Lines not claimed stay general-purpose.
   always_comb begin
      hs_mask = 8'h00;
      hs_drv = 8'h00;
      if (a_hs_in) begin
         hs_mask = hs_mask | 8'h38;
         hs_drv = hs_drv | 8'h28;
      end
      if (a_hs_out) begin
         hs_mask = hs_mask | 8'hC8;
         hs_drv = hs_drv | 8'h88;
      end
      if (b_hs) begin
         hs_mask = hs_mask | 8'h07;
         hs_drv = hs_drv | 8'h03;
      end
   end

   // Requests show only while their enable bit is set.
   assign port_a_irq_request = (intr_ai_q && pc_out_q[`PSH_PC_PORT_A_STROBE_N] && a_hs_in)
      || (intr_ao_q && pc_out_q[`PSH_PC_PORT_A_ACK_N] && a_hs_out);
   assign port_b_irq_request = intr_b_q && pc_out_q[`PSH_PC_PORT_B_STROBE_N] && b_hs;

   // Strobe and acknowledge positions read back their enable, never the pin.
   assign hs_v = {obf_a_n_q, pc_out_q[6], ibf_a_q, pc_out_q[4], port_a_irq_request,
      pc_out_q[2], cfg_q.b_in ? ibf_b_q : obf_b_n_q, port_b_irq_request};
   assign gpio_oe = {{4{!cfg_q.cu_in}}, {4{!cfg_q.cl_in}}};

   ////////////////////////////////////////////////////////////////////////////////
   // Port C output latch, written at its unclaimed lines or one bit at a time.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_out_q <= `PSH_BYTE_RST;
      end else if (mode_wr) begin
         pc_out_q <= `PSH_BYTE_RST;
      end else if (bsr_wr) begin
         pc_out_q[hwdata[3:1]] <= hwdata[0];
      end else if (wr_c) begin
         pc_out_q <= (pc_out_q & hs_mask) | (hwdata[7:0] & ~hs_mask);
      end
   end

   // Lines released at the previous sample; a line just let go by a mode change
   // floats to the far side's level and must not count as a strobe or acknowledge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_was_in_q <= 8'hFF;
      end else begin
         pc_was_in_q <= ~pc_oe;
      end
   end

   // Previous pin sample for edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_prev_q <= 8'hFF;
      end else begin
         pc_prev_q <= pc_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port A handshake flags; a strobe or acknowledge wins over a host access in the same cycle, except on output-full, where the host write wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ibf_a_q <= 1'b0;
         intr_ai_q <= 1'b0;
         obf_a_n_q <= 1'b1;
         intr_ao_q <= 1'b0;
      end else if (mode_wr) begin
         ibf_a_q <= 1'b0;
         intr_ai_q <= 1'b0;
         obf_a_n_q <= 1'b1;
         intr_ao_q <= 1'b0;
      end else begin
         if (stb_a_fall) begin
            ibf_a_q <= 1'b1;
         end else if (rd_a) begin
            ibf_a_q <= 1'b0;
         end
         if (stb_a_rise && ibf_a_q) begin
            intr_ai_q <= 1'b1;
         end else if (rd_a) begin
            intr_ai_q <= 1'b0;
         end
         if (wr_a && a_hs_out) begin
            obf_a_n_q <= 1'b0;
         end else if (ack_a_fall) begin
            obf_a_n_q <= 1'b1;
         end
         if (ack_a_rise) begin
            intr_ao_q <= 1'b1;
         end else if (wr_a) begin
            intr_ao_q <= 1'b0;
         end
      end
   end

   // Port B handshake flags, one direction at a time.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ibf_b_q <= 1'b0;
         obf_b_n_q <= 1'b1;
         intr_b_q <= 1'b0;
      end else if (mode_wr) begin
         ibf_b_q <= 1'b0;
         obf_b_n_q <= 1'b1;
         intr_b_q <= 1'b0;
      end else begin
         if (hs_b_fall && cfg_q.b_in) begin
            ibf_b_q <= 1'b1;
         end else if (rd_b) begin
            ibf_b_q <= 1'b0;
         end
         if (wr_b && b_hs && !cfg_q.b_in) begin
            obf_b_n_q <= 1'b0;
         end else if (hs_b_fall && !cfg_q.b_in) begin
            obf_b_n_q <= 1'b1;
         end
         if (hs_b_rise && (cfg_q.b_in ? ibf_b_q : 1'b1)) begin
            intr_b_q <= 1'b1;
         end else if (rd_b || wr_b) begin
            intr_b_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data latches: input latched on the strobe, output latched on a host write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_in_q <= `PSH_BYTE_RST;
         pb_in_q <= `PSH_BYTE_RST;
      end else begin
         if (stb_a_fall) begin
            pa_in_q <= pa_i;
         end
         if (hs_b_fall && cfg_q.b_in) begin
            pb_in_q <= pb_i;
         end
      end
   end

   // Output latches follow host writes and are cleared by a mode write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_lat_q <= `PSH_BYTE_RST;
         pb_lat_q <= `PSH_BYTE_RST;
      end else if (mode_wr) begin
         pa_lat_q <= `PSH_BYTE_RST;
         pb_lat_q <= `PSH_BYTE_RST;
      end else begin
         if (wr_a) begin
            pa_lat_q <= hwdata[7:0];
         end
         if (wr_b) begin
            pb_lat_q <= hwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers, all registered.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_o <= `PSH_BYTE_RST;
         pa_oe <= 1'b0;
         pb_o <= `PSH_BYTE_RST;
         pb_oe <= 1'b0;
         pc_o <= `PSH_BYTE_RST;
         pc_oe <= 8'h00;
      end else begin
         pa_o <= pa_lat_q;
         if (amode == GA_BIDIR) begin
            pa_oe <= !pc_i[`PSH_PC_PORT_A_ACK_N];
         end else begin
            pa_oe <= !cfg_q.a_in;
         end
         pb_o <= pb_lat_q;
         pb_oe <= !cfg_q.b_in;
         pc_o <= (hs_v & hs_mask) | (pc_out_q & ~hs_mask);
         pc_oe <= hs_drv | (gpio_oe & ~hs_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data and bus answer; zero wait states, always OKAY.
   logic [7:0] rd_val;

   // Value of the addressed register, taken in the address phase.
   always_comb begin
      rd_val = 8'h00;
      if (mapped) begin
         unique case (idx)
            `PSH_IDX_PORTA: rd_val = a_hs_in ? pa_in_q : (cfg_q.a_in ? pa_i : pa_lat_q);
            `PSH_IDX_PORTB: rd_val = !cfg_q.b_in ? pb_lat_q : (b_hs ? pb_in_q : pb_i);
            `PSH_IDX_STATUS1: rd_val = (hs_v & hs_mask)
               | (~hs_mask & ((gpio_oe & pc_out_q) | (~gpio_oe & pc_i)));
            `PSH_IDX_CFG: rd_val = cfg_q;
            default: rd_val = 8'h00;
         endcase
      end
   end

   // Read data is registered at the end of the address phase and stands until the
   // next read, so the master finds it in the whole data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ph && !hwrite) begin
            hrdata <= {24'h000000, rd_val};
         end
      end
   end

endmodule
`default_nettype wire

// file: psh_ppi_asserts.sv
// Purpose: Port-level checks of the strobed handshake parallel port.
// Assumes: Sees only top-level ports; follows mode writes from the bus itself.
// Notes: Pins lag flag registers by one edge, so the pin direction checks use the delayed mode.
`timescale 1ns/1ps
`default_nettype none
module psh_ppi_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [7:0] pc_i,
   input wire logic [7:0] pc_o,
   input wire logic [7:0] pc_oe,
   input wire logic pa_oe
);
   logic wr_q;
   logic [3:0] idx_q;
   logic [7:0] cfg_q;
   logic [7:0] cfg_p;
   logic a_in, a_out, a_outp, a_bi, wr_a;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   // Tracks bus writes so the checker knows the current mode word.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         idx_q <= 4'h0;
         cfg_q <= 8'h9B;
         cfg_p <= 8'h9B;
      end else begin
         wr_q <= hsel & htrans[1] & hready & hwrite;
         idx_q <= haddr[5:2];
         cfg_p <= cfg_q;
         if (wr_q && idx_q == 4'h3 && hwdata[7]) cfg_q <= hwdata[7:0];
      end
   end
   // Decoded modes; the delayed copy lines up with the pins.
   assign wr_a = wr_q && idx_q == 4'h0;
   assign a_in = cfg_q[6:5] == 2'b01 && cfg_q[4];
   assign a_out = cfg_q[6:5] == 2'b01 && !cfg_q[4];
   assign a_outp = cfg_p[6:5] == 2'b01 && !cfg_p[4];
   assign a_bi = cfg_p[6];
   ////////////////////////////////////////////////////////////////////////////
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_in_full: assert property (a_in && $fell(pc_i[4]) |-> ##[1:3] pc_o[5])
      else $error("input full not raised after strobe");
   a_out_full: assert property (a_out && wr_a |-> ##[1:3] !pc_o[7])
      else $error("output full not lowered after write");
   a_ack_frees: assert property (a_out && $fell(pc_i[6]) && !wr_a |-> ##[1:3] pc_o[7])
      else $error("output full not released by acknowledge");
   a_pins_dir: assert property (a_outp |-> pc_oe[7] && !pc_oe[6])
      else $error("handshake pin directions wrong");
   a_bidir_drive: assert property (a_bi && !pc_i[6] [*3] |-> pa_oe)
      else $error("port not driven during acknowledge");
   a_bidir_release: assert property (a_bi && pc_i[6] [*3] |-> !pa_oe)
      else $error("port driven without acknowledge");
   // Main scenarios reached.
   cover property (a_out && wr_a);
   cover property (a_in && $fell(pc_i[4]));
   cover property (a_bi && !pa_oe ##1 pa_oe);
endmodule
`default_nettype wire

// file: psh_periph.sv
// Purpose: Peripheral on the connector that strobes data in and acknowledges.
// Assumes: Handshake lines idle high as with a pull-up.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module psh_periph (
   input wire logic hclk,
   output logic [7:0] pa_drv,
   output logic [7:0] pb_i,
   output logic [7:0] pc_drv
);
   // Idle levels at time zero.
   initial begin
      pa_drv = 8'h00;
      pb_i = 8'h00;
      pc_drv = 8'hFF;
   end
   // Presents a byte and pulls handshake line n low for three cycles.
   task automatic hs(input int n, input logic b, input logic [7:0] d);
      @(posedge hclk);
      if (b) pb_i <= d;
      else pa_drv <= d;
      pc_drv[n] <= 1'b0;
      repeat (3) @(posedge hclk);
      pc_drv[n] <= 1'b1;
      @(posedge hclk);
      if (b) pb_i <= ~d;
      else pa_drv <= ~d;
      @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// file: psh_tb.sv
// Purpose: Self-checking bench of the strobed handshake parallel port.
// Assumes: Bus answers with hreadyout; master waits for it.
// Notes: Wire levels mix the port's drive with the peripheral's.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, pa_oe, pb_oe;
   logic [7:0] pa_o, pb_o, pc_o, pc_oe, pa_drv, pb_i, pc_drv, pa_i, pc_i, q;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2.5 hclk = ~hclk;
   // Resolved pin levels.
   assign pa_i = pa_oe ? pa_o : pa_drv;
   assign pc_i = (pc_oe & pc_o) | (~pc_oe & pc_drv);
   psh_ppi_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pa_i, .pa_o, .pa_oe,
      .pb_i, .pb_o, .pb_oe, .pc_i, .pc_o, .pc_oe);
   psh_periph u_per (.hclk, .pa_drv, .pb_i, .pc_drv);
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One single-word transfer; read data lands in q.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string s, input logic [7:0] a, m, e);
      bus(1'b0, a, 8'h00);
      check(s, q & m, e);
   endtask
   // Reads the status word until all bits of m are set.
   task automatic poll(input logic [7:0] m);
      repeat (40) begin
         bus(1'b0, 8'h08, 8'h00);
         if ((q & m) === m) break;
      end
      check("poll", q & m, m);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rc("config reset", 8'h0C, 8'hFF, 8'h9B);
      wr(8'h18, 8'hFF);
      rc("unmapped", 8'h18, 8'hFF, 8'h00);
   endtask
   task automatic t_in();
      wr(8'h0C, 8'hB0);
      wr(8'h0C, 8'h09);
      fork
         u_per.hs(4, 1'b0, 8'h5A);
         begin
            repeat (2) @(posedge hclk);
            rc("strobe hidden", 8'h08, 8'h10, 8'h10);
         end
      join
      poll(8'h28);
      rc("A data", 8'h00, 8'hFF, 8'h5A);
      rc("A flags cleared", 8'h08, 8'h28, 8'h00);
      wr(8'h0C, 8'h08);
      u_per.hs(4, 1'b0, 8'h66);
      rc("A request gated", 8'h08, 8'h38, 8'h20);
      rc("A data 2", 8'h00, 8'hFF, 8'h66);
      wr(8'h0C, 8'hB6);
      wr(8'h0C, 8'h05);
      u_per.hs(2, 1'b1, 8'hC3);
      poll(8'h07);
      rc("B data", 8'h04, 8'hFF, 8'hC3);
      wr(8'h0C, 8'h04);
      u_per.hs(2, 1'b1, 8'h3C);
      rc("B request gated", 8'h08, 8'h07, 8'h02);
   endtask
   task automatic t_out();
      wr(8'h0C, 8'hA0);
      wr(8'h0C, 8'h0D);
      poll(8'hC0);
      wr(8'h00, 8'h3C);
      rc("A full", 8'h08, 8'hC8, 8'h40);
      check("A pins", pa_o, 8'h3C);
      fork
         u_per.hs(6, 1'b0, 8'h00);
         begin
            repeat (2) @(posedge hclk);
            rc("ack hidden", 8'h08, 8'h40, 8'h40);
         end
      join
      poll(8'h88);
      wr(8'h0C, 8'h0B);
      rc("spare line set", 8'h08, 8'h20, 8'h20);
      check("spare pin", {7'h0, pc_o[5]}, 8'h01);
      wr(8'h0C, 8'h0A);
      rc("spare line clear", 8'h08, 8'h20, 8'h00);
      wr(8'h0C, 8'hA4);
      wr(8'h0C, 8'h05);
      wr(8'h04, 8'h99);
      rc("B full", 8'h08, 8'h07, 8'h04);
      check("B pins", pb_o, 8'h99);
      check("B drive", {7'h0, pb_oe}, 8'h01);
      u_per.hs(2, 1'b1, 8'h00);
      poll(8'h03);
   endtask
   task automatic t_bidir();
      wr(8'h0C, 8'hC0);
      wr(8'h00, 8'h81);
      check("bidir idle", {7'h0, pa_oe}, 8'h00);
      fork
         u_per.hs(6, 1'b0, 8'h00);
         begin
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            check("bidir drive", {7'h0, pa_oe}, 8'h01);
            check("bidir data", pa_o, 8'h81);
         end
      join
      u_per.hs(4, 1'b0, 8'h7E);
      poll(8'h20);
      rc("bidir in", 8'h00, 8'hFF, 8'h7E);
      wr(8'h0C, 8'h01);
      rc("low line free", 8'h08, 8'h01, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Cuts a hang short.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // Main sequence.
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_in();
      t_out();
      t_bidir();
      complete_run();
   end
endmodule
bind psh_ppi_top psh_ppi_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pc_i, .pc_o, .pc_oe, .pa_oe);
`default_nettype wire
